// file: logic/vdec_input_sync.sv
`default_nettype none
// Overview of operation
// - Decode 12.27 to 17.73 MHz pixel rates
// - Words MSB aligned at bit nine
// - Lock counters to embedded timing words, only while eight_bit is low
// - Separator locks mid-sync in vertical group
// - Separator flywheels through active field
// - Subcarrier mode syncs flagged not valid
// - Any of sixteen comb architectures selectable, except variant code 2 and codes above 5, which force the simple comb
// - All six variants share one map
// - Full variant emulates every reduced variant
module vdec_input_sync (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [9:0] video_input_a,               // Composite or luma input
    input  wire logic [9:0] video_input_b,               // Chroma input in YC mode
    input  wire logic       ext_hsync_n,                 // External horizontal sync
    input  wire logic       ext_vsync_n,                 // External vertical sync
    input  wire logic [1:0] sync_source,                 // Embedded, external or separator
    input  wire logic       subcarrier_locked,           // Clock locked to subcarrier
    input  wire logic       eight_bit,                   // Emulate 8-bit variant
    input  wire logic [2:0] variant_sel,                 // Variant to emulate
    input  wire logic [3:0] comb_sel,                    // Requested comb architecture
    output logic            decoded_hsync_out,
    output logic            decoded_vsync_out,
    output logic            sync_valid,                  // Decoded syncs may be trusted
    output logic            locked,                      // A lock event has been seen
    output logic [3:0]      comb_active,                 // Comb architecture in use
    output logic [9:0]      red_cr_out,                  // Aligned input A, MSB at bit 9
    output logic [9:0]      blue_cb_out                  // Aligned input B, MSB at bit 9
);
    // ************************************************************
    // Input synchronisers for the external sync pins
    // ************************************************************
    logic [1:0] hs_sync_reg;                              // Stage 0 is read only by stage 1
    logic [1:0] vs_sync_reg;
    logic       hs_prev_reg;                              // Edge detect on the clean stage
    logic       vs_prev_reg;

    // Two flops before anything looks at an asynchronous pin
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hs_sync_reg <= 2'h3;
            vs_sync_reg <= 2'h3;
            hs_prev_reg <= 1'b1;
            vs_prev_reg <= 1'b1;
        end else begin
            hs_sync_reg <= {hs_sync_reg[0], ext_hsync_n};
            vs_sync_reg <= {vs_sync_reg[0], ext_vsync_n};
            hs_prev_reg <= hs_sync_reg[1];
            vs_prev_reg <= vs_sync_reg[1];
        end
    end

    logic ext_h_fall;                                     // Start of external hsync
    logic ext_v_fall;
    assign ext_h_fall = hs_prev_reg & ~hs_sync_reg[1];
    assign ext_v_fall = vs_prev_reg & ~vs_sync_reg[1];

    // ************************************************************
    // Input word alignment
    // ************************************************************
    logic [9:0] va_w;                                     // Input A after width emulation
    logic [9:0] vb_w;
    // 8-bit parts leave the two low pins open, so force them to zero
    assign va_w = eight_bit ? {video_input_a[9:2], 2'h0} : video_input_a;
    assign vb_w = eight_bit ? {video_input_b[9:2], 2'h0} : video_input_b;

    // ************************************************************
    // Embedded timing word detector
    // ************************************************************
    logic [9:0] w1_reg;                                   // Previous words of the stream
    logic [9:0] w2_reg;
    logic [9:0] w3_reg;
    logic       emb_line;                                 // Timing word marks line start
    logic       emb_field;                                // Timing word marks field start
    logic       vblank_reg;
    logic       vblank_next;

    always_comb begin
        emb_line    = 1'b0;
        emb_field   = 1'b0;
        vblank_next = vblank_reg;
        // Preamble then status word; the H flag set means end of active video
        if (w3_reg == vdec_sync_pkg::PREAMBLE_ONE && w2_reg == vdec_sync_pkg::PREAMBLE_ZERO
            && w1_reg == vdec_sync_pkg::PREAMBLE_ZERO) begin
            vblank_next = va_w[vdec_sync_pkg::XY_V_BIT];
            emb_line    = va_w[vdec_sync_pkg::XY_H_BIT];
            emb_field   = va_w[vdec_sync_pkg::XY_V_BIT] & ~vblank_reg;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            w1_reg     <= 10'h000;
            w2_reg     <= 10'h000;
            w3_reg     <= 10'h000;
            vblank_reg <= 1'b0;
        end else begin
            w1_reg     <= va_w;
            w2_reg     <= w1_reg;
            w3_reg     <= w2_reg;
            vblank_reg <= vblank_next;
        end
    end

    // ************************************************************
    // Internal sync separator
    // ************************************************************
    logic [11:0] tip_len_reg;                             // Width of current sync tip
    logic [11:0] tip_len_next;
    logic [11:0] since_reg;                               // Pixels since last sync midpoint
    logic [11:0] since_next;
    logic        vgroup_reg;                              // Inside the vertical field group
    logic        vgroup_next;
    logic        sep_line;
    logic        sep_field;
    logic        sep_len_ok;
    logic        tip;

    assign tip = va_w < vdec_sync_pkg::SYNC_LEVEL;

    // Lock only while in the vertical group; in the active field, ignore syncs
    always_comb begin
        tip_len_next = tip ? tip_len_reg + 12'h001 : 12'h000;
        since_next   = since_reg + 12'h001;
        vgroup_next  = vgroup_reg;
        sep_line     = 1'b0;
        sep_field    = 1'b0;
        sep_len_ok   = 1'b0;
        if (tip && tip_len_reg > vdec_sync_pkg::LONG_SYNC) begin
            sep_field   = ~vgroup_reg;
            vgroup_next = 1'b1;                           // Long sync opens the group
        end
        if (!tip && tip_len_reg != 12'h000) begin
            if (vgroup_reg) begin
                // Midpoint is half the pulse width back from its trailing edge
                sep_line   = 1'b1;
                sep_len_ok = since_reg > tip_len_reg;
                since_next = {1'b0, tip_len_reg[11:1]};
                if (tip_len_reg <= vdec_sync_pkg::LONG_SYNC && !sep_field) begin
                    vgroup_next = 1'b0;                   // Group over, now flywheel
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tip_len_reg <= 12'h000;
            since_reg   <= 12'h000;
            vgroup_reg  <= 1'b0;
        end else begin
            tip_len_reg <= tip_len_next;
            since_reg   <= since_next;
            vgroup_reg  <= vgroup_next;
        end
    end

    // ************************************************************
    // Source selection and flywheel counters
    // ************************************************************
    vdec_timing_if tim ();
    logic [11:0] pix_cnt;
    logic [11:0] line_cnt;
    logic        lock_reg;                                // A line start has been seen

    always_comb begin
        tim.line_start  = 1'b0;
        tim.field_start = 1'b0;
        tim.len_valid   = 1'b0;
        tim.line_len    = pix_cnt + 12'h001;              // Length of the line just ended
        case (sync_source)
            vdec_sync_pkg::SRC_EMBED: begin
                tim.line_start  = emb_line;
                tim.field_start = emb_field;
                // The first line start has no earlier one to measure from
                tim.len_valid   = emb_line & lock_reg;
            end
            vdec_sync_pkg::SRC_EXT: begin
                tim.line_start  = ext_h_fall;
                tim.field_start = ext_v_fall;
                tim.len_valid   = ext_h_fall & lock_reg;
            end
            vdec_sync_pkg::SRC_SEP: begin
                tim.line_start  = sep_line;
                tim.field_start = sep_field;
                tim.len_valid   = sep_line & sep_len_ok;
                tim.line_len    = since_reg - {1'b0, tip_len_reg[11:1]};
            end
            default: begin
                tim.line_len = pix_cnt + 12'h001;         // Unused code: coast
            end
        endcase
    end

    vdec_flywheel u_flywheel (
        .clock    (clock),
        .rst_n    (rst_n),
        .tim      (tim),
        .pix_cnt  (pix_cnt),
        .line_cnt (line_cnt)
    );

    // ************************************************************
    // Output registers
    // ************************************************************
    logic       hs_next;
    logic       vs_next;
    logic       lock_next;
    logic       valid_next;
    logic [3:0] comb_next;

    // Narrow variants cannot run every comb, so fall back to the simple one
    always_comb begin
        hs_next    = ~(pix_cnt < vdec_sync_pkg::HS_WIDTH);
        vs_next    = ~(line_cnt < vdec_sync_pkg::VS_LINES);
        lock_next  = lock_reg | tim.line_start;
        // Subcarrier clocks flywheel, so decoded syncs are never trusted there
        valid_next = lock_next & ~subcarrier_locked;
        comb_next  = comb_sel;
        if (variant_sel > vdec_sync_pkg::VAR_LAST) begin
            comb_next = vdec_sync_pkg::COMB_SIMPLE;
        end else if (variant_sel != vdec_sync_pkg::VAR_FULL10
                     && variant_sel[1:0] == 2'h2) begin
            comb_next = vdec_sync_pkg::COMB_SIMPLE;
        end
    end

    // Outputs straight from flops; same datapath for any pixel rate
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            decoded_hsync_out <= 1'b1;
            decoded_vsync_out <= 1'b1;
            lock_reg          <= 1'b0;
            sync_valid        <= 1'b0;
            comb_active       <= 4'h0;
            red_cr_out        <= 10'h000;
            blue_cb_out       <= 10'h000;
        end else begin
            decoded_hsync_out <= hs_next;
            decoded_vsync_out <= vs_next;
            lock_reg          <= lock_next;
            sync_valid        <= valid_next;
            comb_active       <= comb_next;
            red_cr_out        <= va_w;
            blue_cb_out       <= vb_w;
        end
    end

    assign locked = lock_reg;
endmodule // vdec_input_sync
`default_nettype wire

// file: logic/vdec_sync_pkg.sv
`default_nettype none
package vdec_sync_pkg;
    // ************************************************************
    // Widths and data alignment
    // ************************************************************
    localparam int unsigned DATA_W      = 10;            // Full word, bit 9 is the MSB
    localparam int unsigned LOW_BITS    = 2;             // Bits dropped on 8-bit variants
    localparam int unsigned CNT_W       = 12;            // Pixel and line counter width
    localparam int unsigned COMB_W      = 4;             // Selects one of sixteen combs
    localparam int unsigned VAR_W       = 3;             // Selects one of six variants
    // ************************************************************
    // Embedded timing word fields
    // ************************************************************
    localparam logic [9:0]  PREAMBLE_ONE  = 10'h3ff;     // First word of a timing code
    localparam logic [9:0]  PREAMBLE_ZERO = 10'h000;     // Second and third words
    localparam int unsigned XY_V_BIT      = 7;           // Vertical blanking flag
    localparam int unsigned XY_H_BIT      = 6;           // End-of-active flag (line start)
    // ************************************************************
    // Sync separator thresholds and defaults
    // ************************************************************
    localparam logic [9:0]  SYNC_LEVEL    = 10'h040;     // Below this the input is sync tip
    localparam logic [11:0] LONG_SYNC     = 12'h040;     // Sync longer than this is vertical
    localparam logic [11:0] LINE_DEFAULT  = 12'h38c;     // Line length before first lock
    localparam logic [11:0] FIELD_LINES   = 12'h106;     // Lines per field when flywheeling
    localparam logic [11:0] HS_WIDTH      = 12'h040;     // Decoded hsync width in pixels
    localparam logic [11:0] VS_LINES      = 12'h003;     // Decoded vsync width in lines
    // ************************************************************
    // Modes and variants
    // ************************************************************
    localparam logic [1:0]  SRC_EMBED     = 2'h0;        // Embedded timing words
    localparam logic [1:0]  SRC_EXT       = 2'h1;        // External sync pins
    localparam logic [1:0]  SRC_SEP       = 2'h2;        // Internal sync separator
    localparam logic [2:0]  VAR_FULL10    = 3'h0;        // 10-bit three-line, emulates all
    localparam logic [2:0]  VAR_LAST      = 3'h5;        // Highest valid variant code
    localparam logic [3:0]  COMB_SIMPLE   = 4'h0;        // Bandsplit-only comb code
endpackage
`default_nettype wire

// file: logic/vdec_timing_if.sv
`default_nettype none
// Carries the lock events from the source selector into the timing counters
interface vdec_timing_if;
    logic        line_start;                              // Begin a new line
    logic        field_start;                             // Begin a new field
    logic [11:0] line_len;                                // Measured line length
    logic        len_valid;                               // line_len is fresh
    modport src (output line_start, field_start, line_len, len_valid);
    modport dst (input  line_start, field_start, line_len, len_valid);
endinterface
`default_nettype wire

// file: logic/vdec_flywheel.sv
`default_nettype none
// ************************************************************
// Free-running horizontal and vertical counters
// ************************************************************
module vdec_flywheel (
    input  wire logic   clock,
    input  wire logic   rst_n,
    vdec_timing_if.dst  tim,
    output logic [11:0] pix_cnt,
    output logic [11:0] line_cnt
);
    logic [11:0] len_reg;                                 // Last locked line length
    logic [11:0] len_next;
    logic [11:0] pix_reg;
    logic [11:0] pix_next;
    logic [11:0] ln_reg;
    logic [11:0] ln_next;

    // Next-state: lock on events, otherwise coast at the last line length
    always_comb begin
        len_next = len_reg;
        pix_next = pix_reg + 12'h001;
        ln_next  = ln_reg;
        if (tim.len_valid) begin
            len_next = tim.line_len;
        end
        if (tim.line_start || pix_reg >= len_reg - 12'h001) begin
            pix_next = 12'h000;
            ln_next  = (ln_reg >= vdec_sync_pkg::FIELD_LINES - 12'h001) ? 12'h000
                                                                         : ln_reg + 12'h001;
        end
        if (tim.field_start) begin
            ln_next = 12'h000;
        end
    end

    // Registers only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            len_reg <= vdec_sync_pkg::LINE_DEFAULT;
            pix_reg <= 12'h000;
            ln_reg  <= 12'h000;
        end else begin
            len_reg <= len_next;
            pix_reg <= pix_next;
            ln_reg  <= ln_next;
        end
    end

    assign pix_cnt  = pix_reg;
    assign line_cnt = ln_reg;
endmodule // vdec_flywheel
`default_nettype wire

// file: bench/vdec_input_sync_assertions.sv
`default_nettype none
// ****
// Port checks for the input sync block
// ****
module vdec_input_sync_checker (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic [9:0] video_input_a,
    input wire logic [9:0] video_input_b,
    input wire logic       ext_hsync_n,
    input wire logic       ext_vsync_n,
    input wire logic [1:0] sync_source,
    input wire logic       subcarrier_locked,
    input wire logic       eight_bit,
    input wire logic [2:0] variant_sel,
    input wire logic [3:0] comb_sel,
    input wire logic       decoded_hsync_out,
    input wire logic       decoded_vsync_out,
    input wire logic       sync_valid,
    input wire logic       locked,
    input wire logic [3:0] comb_active,
    input wire logic [9:0] red_cr_out,
    input wire logic [9:0] blue_cb_out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [11:0] low_cnt_reg;                             // Cycles hsync has been low
    logic [11:0] low_cnt_next;
    // Count the low phase so its width is judged when it ends
    always_comb begin
        low_cnt_next = decoded_hsync_out ? 12'h000 : low_cnt_reg + 12'h001;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_reg <= 12'h000;
        end else begin
            low_cnt_reg <= low_cnt_next;
        end
    end
    // Preamble and a status word with the line start flag
    sequence trs_seq;
        sync_source == vdec_sync_pkg::SRC_EMBED && video_input_a == 10'h3ff
            ##1 video_input_a == 10'h000 [*2] ##1 video_input_a[6];
    endsequence
    align_red_a: assert property (red_cr_out == ($past(video_input_a) & ~{8'h00, {2{$past(eight_bit)}}}))
        else $error("red output misaligned");
    align_blue_a: assert property (blue_cb_out == ($past(video_input_b) & ~{8'h00, {2{$past(eight_bit)}}}))
        else $error("blue output misaligned");
    comb_pick_a: assert property (comb_active == (($past(variant_sel) <= vdec_sync_pkg::VAR_LAST
        && $past(variant_sel[1:0]) != 2'h2) ? $past(comb_sel) : 4'h0)) else $error("wrong comb");
    valid_sub_a: assert property (sync_valid |-> !$past(subcarrier_locked))
        else $error("sync trusted in subcarrier mode");
    valid_lock_a: assert property (sync_valid |-> locked)
        else $error("sync trusted without lock");
    lock_sticky_a: assert property (locked |=> locked)
        else $error("lock dropped");
    hs_width_a: assert property ($rose(decoded_hsync_out) |-> low_cnt_reg == vdec_sync_pkg::HS_WIDTH)
        else $error("hsync width wrong");
    embed_lock_a: assert property (trs_seq |-> ##[1:3] !decoded_hsync_out)
        else $error("no line start after timing code");
    ext_sync_a: assert property (sync_source == vdec_sync_pkg::SRC_EXT && $fell(ext_hsync_n)
        |-> ##[2:6] !decoded_hsync_out) else $error("no line start after pin sync");
    cover property ($rose(locked));
    cover property ($fell(decoded_vsync_out));
    cover property (subcarrier_locked && locked);
endmodule // vdec_input_sync_checker
bind vdec_input_sync vdec_input_sync_checker chk (.clock(clock), .rst_n(rst_n),
    .video_input_a(video_input_a), .video_input_b(video_input_b), .ext_hsync_n(ext_hsync_n),
    .ext_vsync_n(ext_vsync_n), .sync_source(sync_source), .subcarrier_locked(subcarrier_locked),
    .eight_bit(eight_bit), .variant_sel(variant_sel), .comb_sel(comb_sel),
    .decoded_hsync_out(decoded_hsync_out), .decoded_vsync_out(decoded_vsync_out),
    .sync_valid(sync_valid), .locked(locked), .comb_active(comb_active),
    .red_cr_out(red_cr_out), .blue_cb_out(blue_cb_out));
`default_nettype wire

// file: bench/vdec_source.sv
`default_nettype none
// ****
// Digitized video source on the shared pixel clock
// ****
module vdec_source (
    input  wire logic  clock,
    output logic [9:0] vid_a,                            // Composite or luma word
    output logic [9:0] vid_b,                            // Chroma word
    output logic       hs_n,                             // Pin line sync, active low
    output logic       vs_n                              // Pin field sync, active low
);
    timeunit 1ns;
    timeprecision 1ns;
    // Zero words in reset so the first captured word is known
    initial begin
        vid_a = 10'h000;
        vid_b = 10'h000;
        hs_n = 1'b1;
        vs_n = 1'b1;
    end
    // Words change on the falling edge, locked to the pixel clock
    task automatic word(input logic [9:0] a, input logic [9:0] b);
        @(negedge clock);
        vid_a = a;
        vid_b = b;
    endtask
    // Timing code: preamble, status, then back to mid grey
    task automatic trs(input logic [9:0] status);
        word(10'h3ff, 10'h200);
        word(10'h000, 10'h200);
        word(10'h000, 10'h200);
        word(status, 10'h200);
        word(10'h200, 10'h200);
    endtask
    task automatic idle(input int n);
        repeat (n) word(10'h200, 10'h200);
    endtask
    // Short line sync pulse; field sync stays high
    task automatic hpulse();
        @(negedge clock);
        hs_n = 1'b0;
        repeat (8) @(negedge clock);
        hs_n = 1'b1;
    endtask
endmodule // vdec_source
`default_nettype wire

// file: bench/video_decoder_input_sync_lock_bench.sv
`default_nettype none
module video_decoder_input_sync_lock_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clock = 1'b0, rst_n, subcarrier_locked, eight_bit;
    logic       ext_hsync_n, ext_vsync_n, decoded_hsync_out, decoded_vsync_out, sync_valid, locked;
    logic [1:0] sync_source;
    logic [2:0] variant_sel;
    logic [3:0] comb_sel, comb_active;
    logic [9:0] video_input_a, video_input_b, red_cr_out, blue_cb_out;
    int         num_errors = 0, cmp_count = 0, cyc = 0;
    vdec_source src (.clock(clock), .vid_a(video_input_a), .vid_b(video_input_b),
        .hs_n(ext_hsync_n), .vs_n(ext_vsync_n));
    vdec_input_sync DUT (.clock(clock), .rst_n(rst_n), .video_input_a(video_input_a),
        .video_input_b(video_input_b), .ext_hsync_n(ext_hsync_n), .ext_vsync_n(ext_vsync_n),
        .sync_source(sync_source), .subcarrier_locked(subcarrier_locked), .eight_bit(eight_bit),
        .variant_sel(variant_sel), .comb_sel(comb_sel), .decoded_hsync_out(decoded_hsync_out),
        .decoded_vsync_out(decoded_vsync_out), .sync_valid(sync_valid), .locked(locked),
        .comb_active(comb_active), .red_cr_out(red_cr_out), .blue_cb_out(blue_cb_out));
    always #25 clock = ~clock;
    always @(posedge clock) cyc++;
    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Bounded wait for a high-to-low step of the decoded hsync
    task automatic wait_fall(output int t);
        int   i;
        logic hi;
        i = 0;
        hi = 1'b0;
        while (!(hi && decoded_hsync_out === 1'b0) && i < 3000) begin
            hi = hi | (decoded_hsync_out === 1'b1);
            @(posedge clock);
            #1;
            i++;
        end
        if (i >= 3000) num_errors++;
        t = cyc;
    endtask
    task automatic test_align();
        for (int e = 0; e < 2; e++) begin
            src.word(10'h2d7, 10'h15b);
            eight_bit = e[0];
            @(posedge clock);
            #1;
            check("red_cr_out", e ? 12'h2d4 : 12'h2d7, 12'(red_cr_out));
            check("blue_cb_out", e ? 12'h158 : 12'h15b, 12'(blue_cb_out));
        end
        src.word(10'h200, 10'h200);
        eight_bit = 1'b0;
        $display("test align done");
    endtask
    task automatic test_comb();
        for (int v = 0; v < 8; v++) begin
            for (int c = 0; c < 16; c++) begin
                @(negedge clock);
                variant_sel = 3'(v);
                comb_sel = 4'(c);
                @(posedge clock);
                #1;
                check("comb_active", (v <= 5 && v % 4 != 2) ? 12'(c) : 12'h000, 12'(comb_active));
            end
        end
        variant_sel = 3'h0;
        $display("test comb done");
    endtask
    // Two timing codes 300 words apart, then coasting
    task automatic test_embed();
        int t0, t1, t2, w;
        check("locked", 12'h000, 12'(locked));
        fork
            begin
                src.trs(10'h240);
                src.idle(295);
                src.trs(10'h2c0);
            end
            begin
                wait_fall(t0);
                w = 0;
                while (decoded_hsync_out === 1'b0 && w < 200) begin
                    @(posedge clock);
                    #1;
                    w++;
                end
                check("hsync width", 12'h040, 12'(w));
                check("locked", 12'h001, 12'(locked));
                check("sync_valid", 12'h001, 12'(sync_valid));
                wait_fall(t1);
                check("line period", 12'h12c, 12'(t1 - t0));
                repeat (10) @(posedge clock);
                #1;
                check("vsync", 12'h000, 12'(decoded_vsync_out));
                wait_fall(t2);
                check("coast period", 12'h12c, 12'(t2 - t1));
                check("vsync coast", 12'h000, 12'(decoded_vsync_out));
            end
        join
        $display("test embed done");
    endtask
    // Separator: two long tips open the group, a short one closes it, then coast
    task automatic test_sep();
        @(negedge clock);
        sync_source = vdec_sync_pkg::SRC_SEP;
        for (int p = 0; p < 2; p++) begin
            repeat (100) src.word(10'h000, 10'h200);
            src.idle(200);
        end
        repeat (20) src.word(10'h000, 10'h200);
        src.idle(30);
        check("hsync sep lock", 12'h000, 12'(decoded_hsync_out));
        src.idle(100);
        repeat (20) src.word(10'h000, 10'h200);
        src.idle(5);
        check("hsync flywheel", 12'h001, 12'(decoded_hsync_out));
        src.idle(102);
        check("coast before wrap", 12'h001, 12'(decoded_hsync_out));
        src.idle(10);
        check("coast after wrap", 12'h000, 12'(decoded_hsync_out));
        $display("test sep done");
    endtask
    task automatic test_sub();
        @(negedge clock);
        subcarrier_locked = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        check("sync_valid", 12'h000, 12'(sync_valid));
        check("locked", 12'h001, 12'(locked));
        @(negedge clock);
        subcarrier_locked = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        check("sync_valid", 12'h001, 12'(sync_valid));
        $display("test sub done");
    endtask
    task automatic test_ext();
        int t0, t1;
        @(negedge clock);
        sync_source = vdec_sync_pkg::SRC_EXT;
        wait_fall(t0);
        repeat (80) @(posedge clock);
        #1;
        t0 = cyc;
        fork
            src.hpulse();
            wait_fall(t1);
        join
        check("pin delay ok", 12'h001, 12'((t1 - t0) >= 2 && (t1 - t0) <= 7));
        $display("test ext done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Watchdog: the tests need a few thousand cycles
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        test_done();
    end
    initial begin
        rst_n = 1'b0;
        sync_source = vdec_sync_pkg::SRC_EMBED;
        subcarrier_locked = 1'b0;
        eight_bit = 1'b0;
        variant_sel = 3'h0;
        comb_sel = 4'h0;
        repeat (10) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        test_align();
        test_comb();
        test_embed();
        test_sep();
        test_sub();
        test_ext();
        test_done();
    end
endmodule // video_decoder_input_sync_lock_bench
`default_nettype wire
